// File: hdl/tars_pkg.sv
package tars_pkg;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned TRIP_FREE_MIN = 10;
   localparam int unsigned TICK_HZ = 1;
   localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;
   localparam int unsigned TRIP_FREE_S = TRIP_FREE_MIN * 60;
   // ---------------------------------------------------------------
   // settings
   // ---------------------------------------------------------------
   localparam int unsigned NUM_TRIPS = 16;
   localparam logic [3:0] LIMIT_MAX = 4'ha;
   localparam logic [3:0] LIMIT_RST = 4'h0;
   localparam logic [2:0] SEL_COM = 3'h5;
   localparam logic [2:0] SEL_INPUT_PIN_SELECTION = 3'h4;
   localparam logic [2:0] SEL_OPTION = 3'h6;
   localparam logic [2:0] FB_INPUT_PIN_SELECTION = 3'h4;
   localparam logic [2:0] FB_KEEP = 3'h5;
   localparam logic [2:0] FB_RST = 3'h5;
   localparam logic COPY_ALL = 1'b1;
   localparam logic [4:0] LOAD_NONE = 5'h00;
   localparam logic [4:0] LOAD_SET_HI = 5'h04;
   localparam logic [4:0] LOAD_ABCD = 5'h05;
   localparam logic [4:0] LOAD_SETMOT_LO = 5'h06;
   localparam logic [4:0] LOAD_SETMOT_HI = 5'h09;
   localparam logic [4:0] LOAD_ABCD_MOT = 5'h0a;
   localparam logic [4:0] LOAD_MOT_LO = 5'h0b;
   localparam logic [4:0] LOAD_MOT_HI = 5'h0e;
   localparam logic [4:0] LOAD_ALL_MOT = 5'h0f;
   localparam logic [4:0] LOAD_ALL = 5'h10;
endpackage : tars_pkg

// File: hdl/tars_sync.sv
`timescale 1ns/100ps
`default_nettype none
// three-stage synchroniser: output changes once stages two and three agree
module tars_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } tars_sync_s;
   tars_sync_s st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < W; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign q = st_r.q;
endmodule : tars_sync
`default_nettype wire

// File: hdl/tars_delay.sv
`timescale 1ns/100ps
`default_nettype none
// per-trip delay timer: counts ticks once the fault condition is gone
module tars_delay #(
   parameter int unsigned DW = 12
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic tick,
   input wire logic tripped,
   input wire logic cond_active,
   input wire logic [DW-1:0] delay_s,
   output logic expired
);
   typedef struct packed {
      logic [DW-1:0] cnt;
      logic done;
   } tars_delay_s;
   tars_delay_s st_r, st_nxt;
   always_comb begin
      st_nxt = st_r;
      if (!tripped || cond_active) begin
         st_nxt.cnt = '0;
         st_nxt.done = 1'b0;
      end else if (delay_s == '0) begin
         st_nxt.done = 1'b0;
      end else if (tick && !st_r.done) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
         if (st_nxt.cnt >= delay_s) begin
            st_nxt.done = 1'b1;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign expired = st_r.done;
endmodule : tars_delay
`default_nettype wire

// File: hdl/tars_top.sv
`timescale 1ns/100ps
`default_nettype none
// Contract
// [RULE_01] nonzero limit 1..10 enables automatic reset
// [RULE_02] restart only when all conditions are normal
// [RULE_03] counter above limit aborts automatic resetting
// [RULE_04] ten trip-free minutes decrement the counter
// [RULE_05] exhausted limit marks the trip log entry
// [RULE_06] reset-input low-then-high zeroes counter, re-arms
// [RULE_07] remote reset input held high enables autoreset
// [RULE_08] only enabled trips, after their delay expires
// [RULE_09] automatic reset waits for remaining ramp time
// [RULE_10] per trip choose coast or ramp stop
// [RULE_11] start ignored during panel copy or load
// [RULE_12] copy command: 0 none, 1 all
// [RULE_13] load selector codes 0 to 16
// [RULE_14] loaded sets keep their own letters
// [RULE_15] panel transfers leave speed reference alone
// [RULE_16] comm fault switches to fallback set code
// [RULE_17] fallback output flags comm-caused set change
// [RULE_18] fallback active only with serial set select
// [RULE_19] set selector codes 0 to 6
// [RULE_20] trip-free interval from prescaled clock counter
module tars_top
   import tars_pkg::*;
#(
   parameter int unsigned N = tars_pkg::NUM_TRIPS,
   parameter int unsigned DW = 12,
   parameter int unsigned TICK_CYCLES = tars_pkg::TICK_DIV,
   parameter int unsigned FREE_TICKS = tars_pkg::TRIP_FREE_S
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [N-1:0] trip_active,
   input wire logic [N-1:0] autoreset_enable,
   input wire logic [N-1:0] decel_select,
   input wire logic [N*DW-1:0] trip_delay_s,
   input wire logic [3:0] autoreset_attempt_limit,
   input wire logic remote_reset_pin,
   input wire logic manual_reset,
   input wire logic ramp_busy,
   input wire logic start_request,
   input wire logic panel_copy_command,
   input wire logic [4:0] panel_load_select,
   input wire logic panel_busy,
   input wire logic [2:0] set_select,
   input wire logic [2:0] comm_fault_fallback_set,
   input wire logic [1:0] input_pin_selection,
   input wire logic [1:0] serial_set,
   input wire logic [1:0] option_set,
   input wire logic comm_error,
   input wire logic comm_mode_change_set,
   output logic tripped,
   output logic coast_stop,
   output logic ramp_stop,
   output logic autoreset_pulse,
   output logic autoreset_exhausted,
   output logic log_mark_a,
   output logic [3:0] trip_count,
   output logic start_cmd,
   output logic panel_copy_start,
   output logic panel_load_start,
   output logic [3:0] load_set_mask,
   output logic [3:0] load_motor_mask,
   output logic speed_ref_hold,
   output logic [1:0] active_set,
   output logic comm_fallback_active
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum {ST_RUN, ST_TRIP, ST_WAIT_RAMP} tars_mode_e;
   typedef struct packed {
      tars_mode_e mode;
      logic [31:0] pre;
      logic [15:0] free;
      logic [3:0] cnt;
      logic rr_prev;
      logic rr_low_seen;
      logic exhausted;
      logic mark;
      logic ar_pulse;
      logic coast;
      logic ramp;
      logic start;
      logic copy_go;
      logic load_go;
      logic [3:0] smask;
      logic [3:0] mmask;
      logic hold;
      logic [1:0] set;
      logic [1:0] set_before;
      logic fb;
      logic [N-1:0] latched;
   } tars_state_s;
   tars_state_s st_r, st_nxt;

   logic rr_sync;
   logic [N-1:0] expired;
   logic tick;
   logic any_trip;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [3:0] set_onehot(input logic [4:0] code);
      logic [3:0] m;
      m = '0;
      m[2'(code - 5'h01)] = 1'b1;
      return m;
   endfunction : set_onehot

   function automatic logic [1:0] set_pick(input logic [2:0] code, input logic [1:0] pin_set,
                                           input logic [1:0] ser, input logic [1:0] opt,
                                           input logic [1:0] cur);
      logic [1:0] r;
      r = cur;
      if (code < SEL_INPUT_PIN_SELECTION) begin
         r = code[1:0];
      end else if (code == SEL_INPUT_PIN_SELECTION) begin
         r = pin_set;
      end else if (code == SEL_COM) begin
         r = ser;
      end else if (code == SEL_OPTION) begin
         r = opt;
      end
      return r;
   endfunction : set_pick

   tars_sync #(.W(1)) u_rr_sync (
      .clock(clock),
      .srst(srst),
      .d(remote_reset_pin),
      .q(rr_sync)
   );

   // ---------------------------------------------------------------
   // per-trip delay timers
   // ---------------------------------------------------------------
   for (genvar g = 0; g < N; g++) begin : g_dly
      tars_delay #(.DW(DW)) u_dly (
         .clock(clock),
         .srst(srst),
         .tick(tick),
         .tripped(st_r.latched[g]),
         .cond_active(trip_active[g]),
         .delay_s(trip_delay_s[g*DW +: DW]),
         .expired(expired[g])
      );
   end

   assign tick = (st_r.pre == 32'(TICK_CYCLES - 1)); // [RULE_20]
   assign any_trip = |(trip_active & ~st_r.latched);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic enabled;
      logic all_ok;
      logic new_trip;
      logic first_dec;
      enabled = 1'b0;
      all_ok = 1'b0;
      new_trip = 1'b0;
      first_dec = 1'b0;
      st_nxt = st_r;
      st_nxt.ar_pulse = 1'b0;
      st_nxt.copy_go = 1'b0;
      st_nxt.load_go = 1'b0;
      st_nxt.rr_prev = rr_sync;
      st_nxt.pre = tick ? '0 : st_r.pre + 32'h1; // [RULE_20]
      // autoreset enabled only with input high and a nonzero limit
      enabled = rr_sync && (autoreset_attempt_limit != 4'h0)
                && (autoreset_attempt_limit <= LIMIT_MAX); // [RULE_01] [RULE_07]
      new_trip = any_trip;
      st_nxt.latched = st_r.latched | trip_active;
      // ---------------------------------------------------------------
      // trip-free decay of the hidden counter
      // ---------------------------------------------------------------
      if (new_trip) begin
         st_nxt.free = '0; // [RULE_20]
      end else if (tick) begin
         if (st_r.free >= 16'(FREE_TICKS)) begin
            st_nxt.free = '0; // [RULE_20]
            first_dec = 1'b1;
         end else begin
            st_nxt.free = st_r.free + 16'h1;
         end
      end
      if (new_trip && st_r.cnt != 4'hf) begin
         st_nxt.cnt = st_r.cnt + 4'h1;
      end else if (first_dec && st_r.cnt != 4'h0) begin
         st_nxt.cnt = st_r.cnt - 4'h1; // [RULE_04]
      end
      // ---------------------------------------------------------------
      // falling then rising edge of the remote reset input re-arms
      // ---------------------------------------------------------------
      if (!rr_sync && st_r.rr_prev) begin
         st_nxt.rr_low_seen = 1'b1;
      end
      if (rr_sync && !st_r.rr_prev && st_r.rr_low_seen) begin
         st_nxt.cnt = '0; // [RULE_06]
         st_nxt.exhausted = 1'b0;
         st_nxt.mark = 1'b0;
         st_nxt.rr_low_seen = 1'b0;
      end
      if (new_trip && enabled && st_r.cnt >= autoreset_attempt_limit) begin
         st_nxt.exhausted = 1'b1; // [RULE_03]
         st_nxt.mark = 1'b1; // [RULE_05]
      end
      // ---------------------------------------------------------------
      // stop style chosen per trip
      // ---------------------------------------------------------------
      if (new_trip) begin
         st_nxt.coast = |(trip_active & ~decel_select); // [RULE_10]
         st_nxt.ramp = ~st_nxt.coast; // [RULE_10]
      end
      // ---------------------------------------------------------------
      // trip recovery
      // ---------------------------------------------------------------
      all_ok = (trip_active == '0)
               && ((st_r.latched & ~(autoreset_enable & expired)) == '0); // [RULE_02] [RULE_08]
      case (st_r.mode)
         ST_RUN: begin
            if (new_trip) begin
               st_nxt.mode = ST_TRIP;
            end
         end
         ST_TRIP: begin
            if (manual_reset && trip_active == '0) begin
               st_nxt.mode = ST_RUN; // [RULE_06]
               st_nxt.latched = '0;
               st_nxt.coast = 1'b0;
               st_nxt.ramp = 1'b0;
            end else if (enabled && !st_r.exhausted && all_ok
                         && st_r.cnt <= autoreset_attempt_limit) begin // [RULE_03]
               st_nxt.mode = ST_WAIT_RAMP; // [RULE_02]
            end
         end
         ST_WAIT_RAMP: begin
            // a fault that returns during the ramp wait cancels the restart
            if (new_trip || !enabled || st_r.exhausted || !all_ok) begin
               st_nxt.mode = ST_TRIP; // [RULE_02]
            end else if (!ramp_busy) begin
               st_nxt.mode = ST_RUN; // [RULE_09]
               st_nxt.ar_pulse = 1'b1;
               st_nxt.latched = '0;
               st_nxt.coast = 1'b0;
               st_nxt.ramp = 1'b0;
            end
         end
         default: begin
            st_nxt.mode = ST_RUN;
         end
      endcase
      // ---------------------------------------------------------------
      // panel transfers
      // ---------------------------------------------------------------
      st_nxt.hold = panel_busy; // [RULE_15]
      if (!panel_busy && panel_copy_command == COPY_ALL) begin
         st_nxt.copy_go = 1'b1; // [RULE_12]
      end
      if (!panel_busy && panel_load_select != LOAD_NONE && panel_load_select <= LOAD_ALL) begin
         st_nxt.load_go = 1'b1;
         st_nxt.smask = '0;
         st_nxt.mmask = '0;
         if (panel_load_select <= LOAD_SET_HI) begin
            st_nxt.smask = set_onehot(panel_load_select); // [RULE_13] [RULE_14]
         end else if (panel_load_select == LOAD_ABCD) begin
            st_nxt.smask = 4'hf; // [RULE_13]
         end else if (panel_load_select <= LOAD_SETMOT_HI) begin
            st_nxt.smask = set_onehot(5'(panel_load_select - LOAD_ABCD)); // [RULE_13]
            st_nxt.mmask = 4'hf;
         end else if (panel_load_select == LOAD_ABCD_MOT) begin
            st_nxt.smask = 4'hf; // [RULE_13]
            st_nxt.mmask = 4'hf;
         end else if (panel_load_select <= LOAD_MOT_HI) begin
            st_nxt.mmask = set_onehot(5'(panel_load_select - LOAD_ABCD_MOT)); // [RULE_13]
         end else begin
            st_nxt.mmask = 4'hf; // [RULE_13]
            if (panel_load_select == LOAD_ALL) begin
               st_nxt.smask = 4'hf;
            end
         end
      end
      // ---------------------------------------------------------------
      // start gating
      // ---------------------------------------------------------------
      // a launched transfer blocks start until the panel reports busy
      st_nxt.start = start_request && !panel_busy && !st_nxt.copy_go
                     && !st_nxt.load_go && !st_r.copy_go && !st_r.load_go
                     && st_r.mode == ST_RUN; // [RULE_11]
      // ---------------------------------------------------------------
      // parameter set selection and comm-fault fallback
      // ---------------------------------------------------------------
      if (comm_error && comm_mode_change_set && set_select == SEL_COM) begin // [RULE_18]
         if (!st_r.fb) begin
            st_nxt.set_before = st_r.set;
         end
         if (comm_fault_fallback_set < FB_INPUT_PIN_SELECTION) begin
            st_nxt.set = comm_fault_fallback_set[1:0]; // [RULE_16]
         end else if (comm_fault_fallback_set == FB_INPUT_PIN_SELECTION) begin
            st_nxt.set = input_pin_selection; // [RULE_16]
         end
         st_nxt.fb = (comm_fault_fallback_set != FB_KEEP)
                     && (st_nxt.set != (st_r.fb ? st_r.set_before : st_r.set)); // [RULE_17]
      end else begin
         st_nxt.fb = 1'b0;
         st_nxt.set = set_pick(set_select, input_pin_selection, serial_set, option_set,
                               st_r.set); // [RULE_19]
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         st_r <= '{mode: ST_RUN, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign tripped = (st_r.mode != ST_RUN);
   assign coast_stop = st_r.coast;
   assign ramp_stop = st_r.ramp;
   assign autoreset_pulse = st_r.ar_pulse;
   assign autoreset_exhausted = st_r.exhausted;
   assign log_mark_a = st_r.mark;
   assign trip_count = st_r.cnt;
   assign start_cmd = st_r.start;
   assign panel_copy_start = st_r.copy_go;
   assign panel_load_start = st_r.load_go;
   assign load_set_mask = st_r.smask;
   assign load_motor_mask = st_r.mmask;
   assign speed_ref_hold = st_r.hold;
   assign active_set = st_r.set;
   assign comm_fallback_active = st_r.fb;
endmodule : tars_top
`default_nettype wire

// File: tb/tars_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tars_monitor
   import tars_pkg::*;
#(
   parameter int unsigned N = 16
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic [N-1:0] trip_active,
   input wire logic [3:0] autoreset_attempt_limit,
   input wire logic ramp_busy,
   input wire logic start_request,
   input wire logic panel_copy_command,
   input wire logic [4:0] panel_load_select,
   input wire logic panel_busy,
   input wire logic [2:0] set_select,
   input wire logic [2:0] comm_fault_fallback_set,
   input wire logic comm_error,
   input wire logic comm_mode_change_set,
   input wire logic tripped,
   input wire logic autoreset_pulse,
   input wire logic autoreset_exhausted,
   input wire logic log_mark_a,
   input wire logic [3:0] trip_count,
   input wire logic start_cmd,
   input wire logic panel_copy_start,
   input wire logic panel_load_start,
   input wire logic [1:0] active_set,
   input wire logic comm_fallback_active
);
   // ----
   // trip recovery, start gating, set selection
   // ----
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   sequence s_start_ok;
      start_request && !panel_busy && !tripped && !panel_copy_command
         && panel_load_select == 5'h00 && trip_active == '0
         && !panel_copy_start && !panel_load_start;
   endsequence
   sequence s_fb_req;
      set_select == SEL_COM && comm_error && comm_mode_change_set
         && comm_fault_fallback_set < FB_INPUT_PIN_SELECTION;
   endsequence
   chk_pulse_one: assert property (autoreset_pulse |=> !autoreset_pulse)
      else $error("autoreset pulse too long");
   chk_pulse_clear: assert property (autoreset_pulse |-> !tripped && $past(tripped))
      else $error("autoreset without trip clear");
   chk_fault_gone: assert property (autoreset_pulse |-> $past(trip_active) == '0)
      else $error("autoreset while fault present");
   chk_ramp_wait: assert property (autoreset_pulse |-> !$past(ramp_busy))
      else $error("autoreset during ramp");
   chk_limit_on: assert property (autoreset_pulse |->
      $past(autoreset_attempt_limit) inside {[4'h1:LIMIT_MAX]})
      else $error("autoreset with limit off");
   chk_exhaust_stop: assert property (autoreset_exhausted |-> !autoreset_pulse)
      else $error("autoreset after exhaustion");
   chk_exhaust_mark: assert property (autoreset_exhausted |-> log_mark_a)
      else $error("exhausted without log mark");
   chk_count_up: assert property ($rose(tripped) && $past(trip_count) != 4'hf
      |-> trip_count == $past(trip_count) + 4'h1)
      else $error("trip count not incremented");
   chk_start_block: assert property (panel_busy || panel_copy_start || panel_load_start
      |=> !start_cmd)
      else $error("start during panel transfer");
   chk_start_pass: assert property (s_start_ok |=> start_cmd)
      else $error("start not passed");
   chk_fb_switch: assert property (s_fb_req |=>
      {1'b0, active_set} == $past(comm_fault_fallback_set))
      else $error("fallback set not applied");
   chk_fb_flag: assert property (comm_fallback_active |->
      $past(comm_error) && $past(set_select) == SEL_COM)
      else $error("fallback flag without cause");
   chk_fixed_set: assert property (set_select < SEL_INPUT_PIN_SELECTION |=>
      {1'b0, active_set} == $past(set_select))
      else $error("fixed set not applied");
endmodule : tars_monitor
bind tars_top tars_monitor #(.N(N)) u_tars_monitor (.*);
`default_nettype wire

// File: tb/tars_partner.sv
`timescale 1ns/100ps
`default_nettype none
module tars_partner #(
   parameter int BUSY_CYC = 6,
   parameter int RAMP_CYC = 25
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic tripped,
   input wire logic panel_copy_start,
   input wire logic panel_load_start,
   output logic panel_busy,
   output logic ramp_busy
);
   // ----
   // panel transfer time and remaining ramp time
   // ----
   int busy_r;
   int ramp_r;
   logic trip_d_r;
   always_ff @(posedge clock) begin
      trip_d_r <= tripped;
      if (srst) begin
         busy_r <= 0;
         ramp_r <= 0;
      end else begin
         if (panel_copy_start || panel_load_start) begin
            busy_r <= BUSY_CYC;
         end else if (busy_r > 0) begin
            busy_r <= busy_r - 1;
         end
         if (tripped && !trip_d_r) begin
            ramp_r <= RAMP_CYC;
         end else if (ramp_r > 0) begin
            ramp_r <= ramp_r - 1;
         end
      end
   end
   assign panel_busy = busy_r > 0;
   assign ramp_busy = ramp_r > 0;
endmodule : tars_partner
`default_nettype wire

// File: tb/tb_tars_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_tars_top;
   import tars_pkg::*;
   logic clock, srst, remote_reset_pin, manual_reset, ramp_busy, start_request;
   logic panel_copy_command, panel_busy, comm_error, comm_mode_change_set;
   logic [15:0] trip_active, autoreset_enable, decel_select;
   logic [191:0] trip_delay_s;
   logic [3:0] autoreset_attempt_limit, trip_count, load_set_mask, load_motor_mask;
   logic [4:0] panel_load_select;
   logic [2:0] set_select, comm_fault_fallback_set;
   logic [1:0] input_pin_selection, serial_set, option_set, active_set;
   logic tripped, coast_stop, ramp_stop, autoreset_pulse, autoreset_exhausted, log_mark_a;
   logic start_cmd, panel_copy_start, panel_load_start, speed_ref_hold, comm_fallback_active;
   int n_fail = 0;
   int comparisons = 0;
   tars_top #(.TICK_CYCLES(10), .FREE_TICKS(8)) u_tars_top (.*);
   tars_partner u_tars_partner (.*);
   // ----
   // helpers
   // ----
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step
   task automatic cmp_val(input logic [3:0] g, input logic [3:0] e);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask : cmp_val
   task automatic cmp_bit(input logic g, input logic e);
      cmp_val({3'h0, g}, {3'h0, e});
   endtask : cmp_bit
   task automatic do_trip(input int g);
      trip_active[g] = 1'b1;
      step(2);
      trip_active[g] = 1'b0;
   endtask : do_trip
   task automatic wait_pulse(input int lim, output int c);
      c = 0;
      while (autoreset_pulse !== 1'b1 && c < lim) begin
         step(1);
         c++;
      end
   endtask : wait_pulse
   task automatic rearm();
      remote_reset_pin = 1'b0;
      step(6);
      remote_reset_pin = 1'b1;
      step(6);
      cmp_val(trip_count, 4'h0);
      cmp_bit(log_mark_a, 1'b0);
   endtask : rearm
   task automatic test_done();
      $display("counts: %0d compared, %0d mismatched", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   // ----
   // scenarios
   // ----
   task automatic t_autoreset();
      int c;
      autoreset_attempt_limit = 4'h3;
      do_trip(0);
      cmp_bit(ramp_stop, 1'b1);
      wait_pulse(200, c);
      cmp_bit(autoreset_pulse, 1'b1);
      cmp_bit(c >= 22, 1'b1);
      cmp_val(trip_count, 4'h1);
      c = 0;
      while (trip_count !== 4'h0 && c < 150) begin
         step(1);
         c++;
      end
      cmp_bit(c > 20 && c < 150, 1'b1);
      $display("autoreset test done");
   endtask : t_autoreset
   task automatic t_exhaust();
      int c;
      autoreset_attempt_limit = 4'h2;
      for (int g = 1; g < 3; g++) begin
         do_trip(g);
         cmp_bit(coast_stop, 1'b1);
         wait_pulse(200, c);
         cmp_bit(autoreset_pulse, 1'b1);
      end
      cmp_val(trip_count, 4'h2);
      do_trip(3);
      cmp_bit(autoreset_exhausted, 1'b1);
      cmp_bit(log_mark_a, 1'b1);
      wait_pulse(80, c);
      cmp_bit(autoreset_pulse, 1'b0);
      manual_reset = 1'b1;
      step(2);
      manual_reset = 1'b0;
      cmp_bit(tripped, 1'b0);
      cmp_bit(log_mark_a, 1'b1);
      rearm();
      $display("exhaust test done");
   endtask : t_exhaust
   task automatic t_disabled();
      int c;
      for (int k = 0; k < 3; k++) begin
         autoreset_attempt_limit = (k == 0) ? 4'h0 : 4'h3;
         autoreset_enable = (k == 1) ? 16'h0000 : 16'hffff;
         remote_reset_pin = (k != 2);
         step(6);
         do_trip(k + 4);
         wait_pulse(80, c);
         cmp_bit(autoreset_pulse, 1'b0);
         manual_reset = 1'b1;
         step(2);
         manual_reset = 1'b0;
         cmp_bit(tripped, 1'b0);
      end
      rearm();
      $display("disabled test done");
   endtask : t_disabled
   task automatic go_panel(input logic cp, input logic [4:0] ld, input int k);
      int c;
      logic [3:0] es;
      c = 0;
      es = (k < 5) ? 4'h1 << (k - 1) : (k > 5 && k < 10) ? 4'h1 << (k - 6) : 4'h0;
      es = (k == 5 || k == 10 || k == 16) ? 4'hf : es;
      panel_copy_command = cp;
      panel_load_select = ld;
      while ((cp ? panel_copy_start : panel_load_start) !== 1'b1 && c < 20) begin
         step(1);
         c++;
      end
      cmp_bit(cp ? panel_copy_start : panel_load_start, 1'b1);
      if (!cp) begin
         cmp_val(load_set_mask, (k > 10 && k < 16) ? 4'h0 : es);
         cmp_val(load_motor_mask,
                 (k < 6) ? 4'h0 : (k > 10 && k < 15) ? 4'h1 << (k - 11) : 4'hf);
      end
      panel_copy_command = 1'b0;
      panel_load_select = 5'h00;
      step(1);
      cmp_bit(start_cmd, 1'b0);
      step(1);
      cmp_bit(start_cmd, 1'b0);
      cmp_bit(speed_ref_hold, 1'b1);
      step(8);
      cmp_bit(speed_ref_hold, 1'b0);
   endtask : go_panel
   task automatic t_panel();
      start_request = 1'b1;
      step(3);
      cmp_bit(start_cmd, 1'b1);
      go_panel(1'b1, 5'h00, 0);
      for (int k = 1; k < 17; k++) begin
         go_panel(1'b0, 5'(k), k);
      end
      cmp_bit(start_cmd, 1'b1);
      $display("panel test done");
   endtask : t_panel
   task automatic t_sets();
      logic [1:0] e;
      for (int s = 0; s < 7; s++) begin
         set_select = 3'(s);
         step(3);
         e = (s < 4) ? 2'(s) : 2'(s - 3);
         cmp_val({2'h0, active_set}, {2'h0, e});
      end
      set_select = SEL_COM;
      for (int f = 0; f < 6; f++) begin
         comm_fault_fallback_set = 3'(f);
         comm_error = 1'b1;
         step(3);
         e = (f < 4) ? 2'(f) : (f == 4) ? 2'h1 : 2'h2;
         cmp_val({2'h0, active_set}, {2'h0, e});
         cmp_bit(comm_fallback_active, f != 5 && e != serial_set);
         comm_error = 1'b0;
         step(3);
         cmp_bit(comm_fallback_active, 1'b0);
      end
      set_select = 3'h0;
      comm_error = 1'b1;
      step(3);
      cmp_val({2'h0, active_set}, 4'h0);
      cmp_bit(comm_fallback_active, 1'b0);
      comm_error = 1'b0;
      $display("sets test done");
   endtask : t_sets
   // ----
   // run
   // ----
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   initial begin
      #1_000_000;
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end
   initial begin
      srst = 1'b1;
      {remote_reset_pin, comm_mode_change_set} = 2'h3;
      {manual_reset, start_request, panel_copy_command, comm_error} = 4'h0;
      trip_active = 16'h0000;
      autoreset_enable = 16'hffff;
      decel_select = 16'h0001;
      trip_delay_s = {16{12'h001}};
      autoreset_attempt_limit = 4'h0;
      panel_load_select = 5'h00;
      set_select = 3'h0;
      comm_fault_fallback_set = FB_RST;
      {input_pin_selection, serial_set, option_set} = 6'h1b;
      repeat (4) @(posedge clock);
      #1;
      srst = 1'b0;
      step(1);
      t_autoreset();
      t_exhaust();
      t_disabled();
      t_panel();
      t_sets();
      test_done();
   end
endmodule : tb_tars_top
`default_nettype wire
